/* rtl/srctl_pkg.sv */
`default_nettype none
package srctl_pkg;
  // Register offsets inside the 64-byte register block
  localparam logic [5:0] SRCTL_CFG_OFS = 6'h00;
  localparam logic [5:0] SRCTL_TST_OFS = 6'h02;
  // Field positions
  localparam int SRCTL_CFG_STOP_BIT = 15;
  localparam int SRCTL_CFG_SPACE_BIT = 8;
  localparam int SRCTL_TST_CODE_LSB = 9;
  localparam int SRCTL_TST_LOCK_BIT = 8;
  // Values after reset
  localparam logic SRCTL_STOP_RST = 1'b0;
  localparam logic SRCTL_SPACE_RST = 1'b1;
  localparam logic [6:0] SRCTL_CODE_RST = 7'h00;
  // Soft-defect test codes
  localparam logic [6:0] SRCTL_TC_NONE = 7'h00;
  localparam logic [6:0] SRCTL_TC_OC_L0 = 7'h27;
  localparam logic [6:0] SRCTL_TC_OC_L1 = 7'h37;
  localparam logic [6:0] SRCTL_TC_OC_R0 = 7'h2F;
  localparam logic [6:0] SRCTL_TC_OC_R1 = 7'h3F;
  localparam logic [6:0] SRCTL_TC_PRE = 7'h64;
  localparam logic [6:0] SRCTL_TC_CUR = 7'h44;
  // Cycle counts
  localparam int SRCTL_BUS_CYC = 2;
  localparam logic [15:0] SRCTL_PRECOND_CYC = 16'h0040;
  // Access sizes on the array port
  typedef enum logic [1:0] {SRCTL_SZ_BYTE, SRCTL_SZ_WORD, SRCTL_SZ_LONG} srctl_size_t;
endpackage
`default_nettype wire

/* rtl/srctl_mem.sv */
`default_nettype none
module srctl_mem
  import srctl_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Access port
  input wire logic [9:0] addr,
  input wire logic wr,
  input wire logic [1:0] be,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem_q [0:1023];
  logic [15:0] rdata_q;

  // Array has no reset: contents survive every reset, a write cut short may leave junk
  always_ff @(posedge core_clk) begin
    if (wr && be[1]) begin
      mem_q[addr][15:8] <= wdata[15:8];
    end
    if (wr && be[0]) begin
      mem_q[addr][7:0] <= wdata[7:0];
    end
    rdata_q <= mem_q[addr];
  end

  assign rdata = rdata_q;
endmodule // srctl_mem
`default_nettype wire

/* rtl/srctl_test.sv */
`default_nettype none
module srctl_test
  import srctl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Effective test code and its write pulse
  input wire logic [6:0] code,
  input wire logic code_wr,
  // Current comparator against the internal reference
  input wire logic cur_high,
  // Read override
  output logic test_run,
  output logic force_en,
  output logic [15:0] force_val
);
  logic [15:0] cnt_q, cnt_d;

  // Preconditioning timer, restarted on each write of the pretest code
  always_comb begin
    cnt_d = cnt_q;
    if (code_wr && code == SRCTL_TC_PRE) begin
      cnt_d = SRCTL_PRECOND_CYC;
    end else if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Read values a healthy array gives under each test
  always_comb begin
    test_run = (code != SRCTL_TC_NONE);
    force_en = 1'b1;
    force_val = 16'h0000;
    case (code)
      SRCTL_TC_OC_L0: force_val = 16'h0000;
      SRCTL_TC_OC_L1: force_val = 16'hFFFF;
      SRCTL_TC_OC_R0: force_val = 16'h0000;
      SRCTL_TC_OC_R1: force_val = 16'hFFFF;
      SRCTL_TC_PRE: force_val = {15'h0000, (cnt_q == 16'h0000) && !code_wr};
      SRCTL_TC_CUR: force_val = {15'h0000, cur_high};
      default: force_en = 1'b0;
    endcase
  end

  pre_busy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    code_wr && code == SRCTL_TC_PRE |=> !force_val[0] [*8])
    else $error("pretest reported done too early");
  oc_left_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    code == SRCTL_TC_OC_L1 |-> force_en && force_val == 16'hFFFF)
    else $error("left ones test gives wrong value");
  oc_right_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    code == SRCTL_TC_OC_R0 |-> force_en && force_val == 16'h0000)
    else $error("right zeros test gives wrong value");
  test_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    code == SRCTL_TC_NONE |-> !test_run && !force_en)
    else $error("test still running with zero code");
endmodule // srctl_test
`default_nettype wire

/* rtl/srctl_top.sv */
// What this block does
// - Byte or even-address word access completes in one two-clock bus cycle.
// - Long-word or odd-address word access takes two bus cycles, four clocks.
// - Array takes reads and writes of byte, word and long-word size.
// - Synchronous reset lets the current bus cycle finish; long may stop halfway.
// - Asynchronous reset mid-access may corrupt data; no completion promised.
// - Soft-defect tests reachable only in test mode, started by code write.
// - In test mode array works normally unless a test runs; data corrupted.
// - Left-half open tests: code 0100111 reads zeros, 0110111 reads ones.
// - Right-half open tests: code 0101111 reads zeros, 0111111 reads ones.
// - Code 0000000 ends any test and restores normal operation.
// - During pretest reads give bit zero low, then high once complete.
// - Current test read: bit zero low if current fine, high if too high.
// - Stop bit set refuses all array access, keeps data, claims no address.
// - Stop entered and left only by software; clearing bit resumes normal.
// - Emulation mode is chosen by the timer coprocessor, not configuration.
// - Coprocessor reaches array on its own bus with its ROM timing.
// - In emulation normal bus access blocked and control registers ineffective.
// - Stop bit is config bit 15, resets to zero, one means stop.
// - Test register writable only in test mode; else reads zero, writes ignored.
// - Test results appear on bit zero of read data or in the array.
//
// Added by the designer: strobed register access and the placing of the registers.
`default_nettype none
module srctl_top
  import srctl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sync_rst,
  // Chip state
  input wire logic test_mode,
  input wire logic cur_high,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Array access from the intermodule bus
  input wire logic arr_req,
  input wire logic [10:0] arr_addr,
  input wire srctl_size_t arr_size,
  input wire logic arr_wr,
  input wire logic [31:0] arr_wdata,
  output logic arr_claim,
  output logic arr_busy,
  output logic arr_ack,
  output logic [31:0] arr_rdata,
  // Timer coprocessor microcode bus
  input wire logic emu_sel,
  input wire logic [9:0] emu_addr,
  output logic [15:0] emu_rdata,
  // Status
  output logic stop_mode
);
  typedef enum logic [2:0] {ST_IDLE, ST_A1, ST_B1, ST_A2, ST_B2} srctl_state_t;

  srctl_state_t state_q, state_d;
  logic stop_q, stop_d, space_q, space_d, lock_q, lock_d;
  logic [6:0] code_q, code_d;
  logic [15:0] rdat_q, rdat_d;
  logic [10:0] addr_q, addr_d;
  srctl_size_t size_q, size_d;
  logic wr_q, wr_d, ack_q, ack_d;
  logic [31:0] wdat_q, wdat_d, acc_q, acc_d, out_q, out_d;
  logic stop_eff, take, two, second, cyc_byte, code_wr;
  logic [10:0] cyc_addr;
  logic [9:0] m_addr;
  logic [1:0] m_be;
  logic m_wr;
  logic [15:0] m_wdata, m_rdata, rd_word;
  logic [7:0] rd_byte;
  logic test_run, force_en;
  logic code_wr_q, code_wr_d;
  logic [15:0] force_val;

  // Byte lanes: the even byte of a word is its high-order byte
  function automatic logic [1:0] lanes(input logic is_byte, input logic odd);
    if (!is_byte) begin
      lanes = 2'b11;
    end else if (odd) begin
      lanes = 2'b01;
    end else begin
      lanes = 2'b10;
    end
  endfunction

  assign stop_eff = stop_q && !emu_sel;
  assign stop_mode = stop_eff;
  assign arr_claim = arr_req && !stop_eff && !emu_sel;
  assign arr_busy = (state_q != ST_IDLE);
  assign take = arr_claim && (state_q == ST_IDLE);
  assign code_wr = reg_wr && reg_addr == SRCTL_TST_OFS && test_mode;

  // Register writes and read data, answered the cycle after the strobe
  always_comb begin
    stop_d = stop_q;
    space_d = space_q;
    code_d = code_q;
    lock_d = lock_q;
    rdat_d = 16'h0000;
    // Pulse delayed one clock so the test block sees it beside the new code, not the old one
    code_wr_d = code_wr && !emu_sel;
    if (reg_wr && reg_addr == SRCTL_CFG_OFS) begin
      stop_d = reg_wdata[SRCTL_CFG_STOP_BIT];
      space_d = reg_wdata[SRCTL_CFG_SPACE_BIT];
    end else if (code_wr) begin
      code_d = reg_wdata[SRCTL_TST_CODE_LSB +: 7];
      lock_d = reg_wdata[SRCTL_TST_LOCK_BIT];
    end
    if (!test_mode) begin
      // Leaving test mode drops any test, so the array cannot stay corrupted
      code_d = SRCTL_CODE_RST;
      lock_d = 1'b0;
    end
    if (reg_rd && reg_addr == SRCTL_CFG_OFS) begin
      rdat_d[SRCTL_CFG_STOP_BIT] = stop_q;
      rdat_d[SRCTL_CFG_SPACE_BIT] = space_q;
    end else if (reg_rd && reg_addr == SRCTL_TST_OFS && test_mode) begin
      rdat_d[SRCTL_TST_CODE_LSB +: 7] = code_q;
      rdat_d[SRCTL_TST_LOCK_BIT] = lock_q;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_q <= SRCTL_STOP_RST;
      space_q <= SRCTL_SPACE_RST;
      code_q <= SRCTL_CODE_RST;
      lock_q <= 1'b0;
      code_wr_q <= 1'b0;
      rdat_q <= 16'h0000;
    end else begin
      stop_q <= stop_d;
      space_q <= space_d;
      code_q <= code_d;
      lock_q <= lock_d;
      code_wr_q <= code_wr_d;
      rdat_q <= rdat_d;
    end
  end

  assign reg_rdata = rdat_q;

  // two cycles for long or odd word
  assign two = (size_q == SRCTL_SZ_LONG) || (size_q == SRCTL_SZ_WORD && addr_q[0]);
  assign second = (state_q == ST_A2) || (state_q == ST_B2);
  assign cyc_byte = (size_q == SRCTL_SZ_BYTE) || (size_q == SRCTL_SZ_WORD && addr_q[0]);
  always_comb begin
    cyc_addr = addr_q;
    if (second) begin
      cyc_addr = addr_q + ((size_q == SRCTL_SZ_LONG) ? 11'h002 : 11'h001);
    end
  end

  // Memory port: the coprocessor owns it outright while emulating
  always_comb begin
    m_addr = cyc_addr[10:1];
    m_be = lanes(cyc_byte, cyc_addr[0]);
    m_wr = wr_q && !test_run && (state_q == ST_A1 || state_q == ST_A2);
    m_wdata = wdat_q[15:0];
    if (size_q == SRCTL_SZ_LONG && !second) begin
      m_wdata = wdat_q[31:16];
    end else if (cyc_byte && size_q == SRCTL_SZ_WORD && !second) begin
      m_wdata = {wdat_q[15:8], wdat_q[15:8]};
    end else if (cyc_byte) begin
      m_wdata = {wdat_q[7:0], wdat_q[7:0]};
    end
    if (emu_sel) begin
      m_addr = emu_addr;
      m_be = 2'b00;
      m_wr = 1'b0;
    end
  end

  assign rd_word = force_en ? force_val : m_rdata;
  assign rd_byte = cyc_addr[0] ? rd_word[7:0] : rd_word[15:8];

  // Access sequencer: each bus cycle is an issue clock then a capture clock
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    size_d = size_q;
    wr_d = wr_q;
    wdat_d = wdat_q;
    acc_d = acc_q;
    out_d = out_q;
    ack_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_A1;
          addr_d = (arr_size == SRCTL_SZ_LONG) ? {arr_addr[10:1], 1'b0} : arr_addr;
          size_d = arr_size;
          wr_d = arr_wr;
          wdat_d = arr_wdata;
          acc_d = 32'h0000_0000;
        end
      end
      ST_A1: state_d = ST_B1;
      ST_B1: begin
        acc_d = cyc_byte ? {acc_q[23:0], rd_byte} : {acc_q[15:0], rd_word};
        if (size_q == SRCTL_SZ_LONG && sync_rst) begin
          state_d = ST_IDLE;
        end else if (two) begin
          state_d = ST_A2;
        end else begin
          state_d = ST_IDLE;
          ack_d = 1'b1;
          out_d = cyc_byte ? {acc_q[23:0], rd_byte} : {acc_q[15:0], rd_word};
        end
      end
      ST_A2: state_d = ST_B2;
      ST_B2: begin
        state_d = ST_IDLE;
        ack_d = 1'b1;
        out_d = cyc_byte ? {acc_q[23:0], rd_byte} : {acc_q[15:0], rd_word};
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      addr_q <= 11'h000;
      size_q <= SRCTL_SZ_BYTE;
      wr_q <= 1'b0;
      wdat_q <= 32'h0000_0000;
      acc_q <= 32'h0000_0000;
      out_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      size_q <= size_d;
      wr_q <= wr_d;
      wdat_q <= wdat_d;
      acc_q <= acc_d;
      out_q <= out_d;
      ack_q <= ack_d;
    end
  end

  assign arr_ack = ack_q;
  assign arr_rdata = out_q;
  assign emu_rdata = m_rdata;

  srctl_mem u_mem (
    .core_clk(core_clk),
    .addr(m_addr),
    .wr(m_wr),
    .be(m_be),
    .wdata(m_wdata),
    .rdata(m_rdata)
  );

  srctl_test u_test (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .code((test_mode && !emu_sel) ? code_q : SRCTL_TC_NONE),
    .code_wr(code_wr_q),
    .cur_high(cur_high),
    .test_run(test_run),
    .force_en(force_en),
    .force_val(force_val)
  );

  short_acc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    take && (arr_size == SRCTL_SZ_BYTE || (arr_size == SRCTL_SZ_WORD && !arr_addr[0]))
    |-> !arr_ack ##1 !arr_ack [*2] ##1 arr_ack)
    else $error("short access not done in one bus cycle");
  long_acc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    take && arr_size == SRCTL_SZ_LONG |-> ##5 (arr_ack || $past(sync_rst, 3)))
    else $error("long access not done in two bus cycles");
  sync_finish_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == ST_A1 && sync_rst |=> state_q == ST_B1)
    else $error("bus cycle cut by synchronous reset");
  stop_refuse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    stop_eff && state_q == ST_IDLE |-> !arr_claim ##1 state_q == ST_IDLE)
    else $error("access started in stop mode");
  emu_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    emu_sel && state_q == ST_IDLE |=> state_q == ST_IDLE && !m_wr)
    else $error("bus access during emulation");
  stop_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_addr == SRCTL_CFG_OFS |=> stop_q == $past(reg_wdata[15]))
    else $error("stop bit did not follow write");
  test_hide_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == SRCTL_TST_OFS && !test_mode |=> reg_rdata == 16'h0000)
    else $error("test register visible outside test mode");
endmodule // srctl_top
`default_nettype wire

/* tb/srctl_cpu_model.sv */
`default_nettype none
module srctl_cpu_model
  import srctl_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Request lines
  output var logic arr_req,
  output var logic [10:0] arr_addr,
  output var srctl_size_t arr_size,
  output var logic arr_wr,
  output var logic [31:0] arr_wdata,
  // Answer lines
  input wire logic arr_ack,
  input wire logic [31:0] arr_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle lines start driven so nothing floats at time zero
  initial begin
    arr_req = 1'b0;
    arr_addr = 11'h000;
    arr_size = SRCTL_SZ_BYTE;
    arr_wr = 1'b0;
    arr_wdata = 32'h0000_0000;
  end

  // Hold the request to the take edge, then scramble released address, write and data lines so stale values never help
  task automatic access(input srctl_size_t sz, input logic [10:0] a, input logic w,
      input logic [31:0] d, output int lat, output logic [31:0] q);
    int i;
    lat = 0;
    q = 32'h0000_0000;
    @(posedge core_clk);
    arr_req <= 1'b1;
    arr_addr <= a;
    arr_size <= sz;
    arr_wr <= w;
    arr_wdata <= d;
    @(posedge core_clk);
    arr_req <= 1'b0;
    arr_addr <= ~a;
    arr_wr <= ~w;
    arr_wdata <= ~d;
    // Bounded wait; zero latency means no answer came
    for (i = 1; i <= 12 && lat == 0; i++) begin
      @(posedge core_clk);
      #1;
      // Ack seen just after its launch edge is sampled high at the next edge
      if (arr_ack === 1'b1) begin
        lat = i + 1;
        q = arr_rdata;
      end
    end
  endtask
endmodule // srctl_cpu_model
`default_nettype wire

/* tb/srctl_tb_top.sv */
`default_nettype none
module srctl_tb_top
  import srctl_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

  logic core_clk, sys_rst, sync_rst, test_mode, cur_high;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, emu_rdata;
  logic reg_wr, reg_rd, emu_sel, stop_mode, arr_req, arr_wr, arr_claim, arr_busy, arr_ack;
  logic [9:0] emu_addr;
  logic [10:0] arr_addr;
  srctl_size_t arr_size;
  logic [31:0] arr_wdata, arr_rdata, q;
  int miscompares = 0;
  int n_compared = 0;

  srctl_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sync_rst(sync_rst),
    .test_mode(test_mode), .cur_high(cur_high), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_req(arr_req),
    .arr_addr(arr_addr), .arr_size(arr_size), .arr_wr(arr_wr), .arr_wdata(arr_wdata),
    .arr_claim(arr_claim), .arr_busy(arr_busy), .arr_ack(arr_ack), .arr_rdata(arr_rdata),
    .emu_sel(emu_sel), .emu_addr(emu_addr), .emu_rdata(emu_rdata), .stop_mode(stop_mode));

  srctl_cpu_model i_cpu (.core_clk(core_clk), .arr_req(arr_req), .arr_addr(arr_addr),
    .arr_size(arr_size), .arr_wr(arr_wr), .arr_wdata(arr_wdata), .arr_ack(arr_ack),
    .arr_rdata(arr_rdata));

  // Clock at 40 MHz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic acc(input srctl_size_t sz, input logic [10:0] a, input logic w,
      input logic [31:0] d, input int exp_lat);
    int lat;
    i_cpu.access(sz, a, w, d, lat, q);
    `CHK(lat, exp_lat)
  endtask

  // reset values and locked test register
  task automatic t_regs();
    logic [15:0] v;
    reg_read(SRCTL_CFG_OFS, v);
    `CHK(v, 16'h0100)
    reg_write(SRCTL_TST_OFS, {SRCTL_TC_OC_L1, 9'h000});
    reg_read(SRCTL_TST_OFS, v);
    `CHK(v, 16'h0000)
    reg_read(6'h3E, v);
    `CHK(v, 16'h0000)
  endtask

  task automatic t_access();
    acc(SRCTL_SZ_WORD, 11'h010, 1'b1, 32'h0000_A1B2, 3);
    acc(SRCTL_SZ_LONG, 11'h020, 1'b1, 32'h1122_3344, 5);
    acc(SRCTL_SZ_BYTE, 11'h011, 1'b1, 32'h0000_005A, 3);
    acc(SRCTL_SZ_WORD, 11'h010, 1'b0, 32'h0000_0000, 3);
    `CHK(q, 32'h0000_A15A)
    acc(SRCTL_SZ_LONG, 11'h020, 1'b0, 32'h0000_0000, 5);
    `CHK(q, 32'h1122_3344)
    acc(SRCTL_SZ_WORD, 11'h021, 1'b0, 32'h0000_0000, 5);
    `CHK(q, 32'h0000_2233)
  endtask

  // stop refuses access and keeps data
  task automatic t_stop();
    reg_write(SRCTL_CFG_OFS, 16'h8100);
    #1;
    `CHK(stop_mode, 1'b1)
    fork
      acc(SRCTL_SZ_WORD, 11'h010, 1'b1, 32'h0000_FFFF, 0);
      begin
        @(posedge core_clk);
        #1;
        `CHK(arr_claim, 1'b0)
      end
    join
    acc(SRCTL_SZ_WORD, 11'h010, 1'b0, 32'h0000_0000, 0);
    reg_write(SRCTL_CFG_OFS, 16'h0100);
    acc(SRCTL_SZ_WORD, 11'h010, 1'b0, 32'h0000_0000, 3);
    `CHK(q, 32'h0000_A15A)
  endtask

  // every open-circuit code over both array ends
  task automatic t_open();
    logic [6:0] codes [4];
    logic [15:0] v;
    codes = '{SRCTL_TC_OC_L0, SRCTL_TC_OC_L1, SRCTL_TC_OC_R0, SRCTL_TC_OC_R1};
    @(posedge core_clk);
    test_mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      reg_write(SRCTL_TST_OFS, {codes[i], 9'h000});
      reg_read(SRCTL_TST_OFS, v);
      `CHK(v, {codes[i], 9'h000})
      for (int j = 0; j < 2; j++) begin
        acc(SRCTL_SZ_LONG, j ? 11'h7FC : 11'h000, 1'b0, 32'h0000_0000, 5);
        `CHK(q, (i % 2) ? 32'hFFFF_FFFF : 32'h0000_0000)
      end
    end
    reg_write(SRCTL_TST_OFS, 16'h0000);
    acc(SRCTL_SZ_WORD, 11'h010, 1'b1, 32'h0000_1234, 3);
    acc(SRCTL_SZ_WORD, 11'h010, 1'b0, 32'h0000_0000, 3);
    `CHK(q, 32'h0000_1234)
  endtask

  // pretest then current test, long word at zero written all ones then all zeros
  task automatic t_current();
    for (int k = 0; k < 2; k++) begin
      acc(SRCTL_SZ_LONG, 11'h000, 1'b1, k ? 32'h0000_0000 : 32'hFFFF_FFFF, 5);
      reg_write(SRCTL_TST_OFS, {SRCTL_TC_PRE, 9'h000});
      acc(SRCTL_SZ_WORD, 11'h000, 1'b0, 32'h0000_0000, 3);
      `CHK(q[0], 1'b0)
      for (int n = 0; n < 30 && q[0] !== 1'b1; n++) begin
        acc(SRCTL_SZ_WORD, 11'h000, 1'b0, 32'h0000_0000, 3);
      end
      `CHK(q[0], 1'b1)
      cur_high <= k ? 1'b0 : 1'b1;
      reg_write(SRCTL_TST_OFS, {SRCTL_TC_CUR, 9'h000});
      // Settling wait kept short of the real figure to keep the run brief
      repeat (40) @(posedge core_clk);
      acc(SRCTL_SZ_WORD, 11'h7FE, 1'b0, 32'h0000_0000, 3);
      `CHK(q[0], k ? 1'b0 : 1'b1)
      reg_write(SRCTL_TST_OFS, 16'h0000);
    end
    @(posedge core_clk);
    test_mode <= 1'b0;
  endtask

  // sync reset in the first half of a long write keeps only the first word
  task automatic t_sync();
    acc(SRCTL_SZ_LONG, 11'h030, 1'b1, 32'h0000_0000, 5);
    fork
      acc(SRCTL_SZ_LONG, 11'h030, 1'b1, 32'hDEAD_BEEF, 0);
      begin
        repeat (3) @(posedge core_clk);
        sync_rst <= 1'b1;
        #1;
        `CHK(arr_busy, 1'b1)
        @(posedge core_clk);
        sync_rst <= 1'b0;
      end
    join
    acc(SRCTL_SZ_LONG, 11'h030, 1'b0, 32'h0000_0000, 5);
    `CHK(q, 32'hDEAD_0000)
  endtask

  // coprocessor owns the array, registers inert
  task automatic t_emu();
    @(posedge core_clk);
    emu_sel <= 1'b1;
    emu_addr <= 10'h008;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(emu_rdata, 16'h1234)
    acc(SRCTL_SZ_WORD, 11'h010, 1'b0, 32'h0000_0000, 0);
    reg_write(SRCTL_CFG_OFS, 16'h8100);
    #1;
    `CHK(stop_mode, 1'b0)
    @(posedge core_clk);
    emu_sel <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(stop_mode, 1'b1)
    reg_write(SRCTL_CFG_OFS, 16'h0100);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    sync_rst = 1'b0;
    test_mode = 1'b0;
    cur_high = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    emu_sel = 1'b0;
    emu_addr = 10'h000;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_access();
    t_stop();
    t_open();
    t_current();
    t_sync();
    t_emu();
    give_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400us;
    miscompares++;
    give_verdict();
  end
endmodule // srctl_tb_top
`default_nettype wire
